//--- adc_conversion_sequencer_tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "adcs_defines.vh"
module adc_conversion_sequencer_tb_top;
reg		pclk;
reg		presetn;
reg		ce;
reg		psel;
reg		penable;
reg		pwrite;
reg [11:0]	paddr;
reg [31:0]	pwdata;
reg [11:0]	ain;
reg [15:0]	lfsr;
reg [31:0]	rd;
reg		er;
wire		cmp_in;
wire		pready;
wire		pslverr;
wire [31:0]	prdata;
wire		sample_en;
wire		discharge_en;
wire		conv_busy;
wire [11:0]	dac_code;
wire		irq;
integer		miscompares;
integer		checks_done;
integer		n;
integer		i;
// comparator is asynchronous, so it follows the trial code at once
assign cmp_in = ain >= dac_code;
adcs_sequencer dut
(
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .cmp_in(cmp_in), .sample_en(sample_en),
	.discharge_en(discharge_en), .conv_busy(conv_busy), .dac_code(dac_code), .irq(irq)
);
function [15:0] nxt(input [15:0] v);
	nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction
function integer tad_of(input [2:0] c);
	tad_of = c[1:0] == 2'h3 ? 100 : 2 << (c[2] + 2 * c[1:0]);
endfunction
function integer acq_len(input integer a);
	acq_len = a < 5 ? 2 * a : 4 * (a - 2);
endfunction
task close_out;
begin
	$display("checks %0d miscompares %0d", checks_done, miscompares);
	if (miscompares == 0 && checks_done > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
end
endtask
task hang;
begin
	miscompares = miscompares + 1;
	close_out;
end
endtask
task check(input string nm, input [32:0] seen, input [32:0] exp);
begin
	checks_done = checks_done + 1;
	if (seen !== exp)
	begin
		miscompares = miscompares + 1;
		$display("FAIL %0s exp %h seen %h", nm, exp, seen);
	end
end
endtask
task apb(input w, input [11:0] a, input [31:0] d);
begin
	@(posedge pclk);
	psel <= 1'h1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'h1;
	n = 0;
	@(posedge pclk);
	while (pready !== 1'h1)
	begin
		n = n + 1;
		if (n > 50)
			hang;
		@(posedge pclk);
	end
	rd = prdata;
	er = pslverr;
	psel <= 1'h0;
	penable <= 1'h0;
end
endtask
task till(input s, input v);
begin
	n = 0;
	while ((s ? sample_en : conv_busy) !== v)
	begin
		@(negedge pclk);
		n = n + 1;
		if (n > 3000)
			hang;
	end
end
endtask
task conv(input [2:0] cs, input [2:0] aq, input integer tad, input integer w);
begin
	lfsr = nxt(lfsr);
	// two-clock bit periods are below the minimum, only full scale stays defined there
	ain <= cs == 3'h0 ? 12'hFFF : lfsr[11:0];
	apb(1'h1, `ADCS_OFF_CONFIG, {26'h0, aq, cs});
	till(1'h1, 1'h1);
	apb(1'h1, `ADCS_OFF_CTRL, 32'h3);
	till(1'h0, 1'h1);
	check("acq wait", n, w + 2);
	till(1'h0, 1'h0);
	check("conv len", n, 13 * tad);
	repeat (2) @(negedge pclk);
	check("irq set", irq, 1);
	apb(1'h0, `ADCS_OFF_RESULT, 32'h0);
	check("result", rd, ain);
	apb(1'h0, `ADCS_OFF_STATUS, 32'h0);
	check("done", rd, 1);
	apb(1'h0, `ADCS_OFF_CTRL, 32'h0);
	check("start clear", rd[1], 0);
	check("irq clear", irq, 0);
end
endtask
initial
begin
	pclk = 1'h0;
	forever #12.5 pclk = ~pclk;
end
initial
begin
	presetn = 1'h0;
	ce = 1'h1;
	psel = 1'h0;
	penable = 1'h0;
	pwrite = 1'h0;
	paddr = 12'h000;
	pwdata = 32'h0;
	ain = 12'h000;
	lfsr = 16'hC488;
	miscompares = 0;
	checks_done = 0;
	repeat (4) @(posedge pclk);
	presetn <= 1'h1;
	for (i = 0; i < 7; i = i + 1)
	begin
		apb(1'h0, {i[9:0], 2'h0}, 32'h0);
		check("reset", {er, rd}, i == 5 ? 1 : i == 6 ? 33'h100000000 : 0);
	end
	@(posedge pclk);
	ce <= 1'h0;
	@(negedge pclk);
	check("stall", pready, 0);
	@(posedge pclk);
	ce <= 1'h1;
	$display("test reset done");
	apb(1'h1, `ADCS_OFF_MASK, 32'h3);
	apb(1'h1, `ADCS_OFF_CTRL, 32'h1);
	repeat (80) @(posedge pclk);
	for (i = 0; i < 16; i = i + 1)
		if (i < 8)
			conv(i[2:0], 3'h0, tad_of(i[2:0]), 4);
		else
			conv(3'h4, i[2:0], 4, i == 8 ? 4 : 4 * acq_len(i - 8));
	$display("test conversions done");
	apb(1'h1, `ADCS_OFF_RESULT, 32'h5A5);
	apb(1'h1, `ADCS_OFF_MASK, 32'h1);
	apb(1'h1, `ADCS_OFF_CONFIG, 32'h1);
	till(1'h1, 1'h1);
	apb(1'h1, `ADCS_OFF_CTRL, 32'h3);
	till(1'h0, 1'h1);
	repeat (20) @(negedge pclk);
	apb(1'h1, `ADCS_OFF_CTRL, 32'h1);
	till(1'h0, 1'h0);
	check("abort", n < 3, 1);
	apb(1'h0, `ADCS_OFF_RESULT, 32'h0);
	check("kept", rd, 32'h5A5);
	check("masked", irq, 0);
	apb(1'h0, `ADCS_OFF_STATUS, 32'h0);
	check("abort flag", rd, 2);
	$display("test abort done");
	close_out;
end
endmodule

//--- adcs_defines.vh
// constants for the conversion sequencer: register map, fields, resets and timing
`ifndef ADCS_DEFINES_VH
`define ADCS_DEFINES_VH

// register byte offsets
`define ADCS_OFF_CTRL       12'h000
`define ADCS_OFF_CONFIG     12'h004
`define ADCS_OFF_RESULT     12'h008
`define ADCS_OFF_STATUS     12'h00C
`define ADCS_OFF_MASK       12'h010
`define ADCS_OFF_STATE      12'h014

// control register fields
`define ADCS_CTRL_ENABLE    0
`define ADCS_CTRL_START     1

// acq_clock_config fields
`define ADCS_CLK_SEL_LSB    0
`define ADCS_CLK_SEL_MSB    2
`define ADCS_ACQ_SEL_LSB    3
`define ADCS_ACQ_SEL_MSB    5

// status and mask fields
`define ADCS_ST_DONE        0
`define ADCS_ST_ABORT       1
`define ADCS_ST_WIDTH       2

// reset values
`define ADCS_CTRL_RST       2'h0
`define ADCS_CLK_SEL_RST    3'h0
`define ADCS_ACQ_SEL_RST    3'h0
`define ADCS_RESULT_RST     12'h000
`define ADCS_STATUS_RST     2'h0
`define ADCS_MASK_RST       2'h0

// conversion clock selector codes
`define ADCS_CLK_DIV2       3'h0
`define ADCS_CLK_DIV4       3'h4
`define ADCS_CLK_DIV8       3'h1
`define ADCS_CLK_DIV16      3'h5
`define ADCS_CLK_DIV32      3'h2
`define ADCS_CLK_DIV64      3'h6

// timing
`define ADCS_PCLK_NS        25
`define ADCS_RC_TAD_NS      2500
`define ADCS_RC_TAD_CYC     (`ADCS_RC_TAD_NS / `ADCS_PCLK_NS)
`define ADCS_INSTR_CYC      4
`define ADCS_HOLDOFF_INSTR  2
`define ADCS_HOLDOFF_CYC    (`ADCS_HOLDOFF_INSTR * `ADCS_INSTR_CYC)
`define ADCS_DISCH_CYC      4
`define ADCS_CONV_TADS      13
`define ADCS_RES_BITS       12

// counter end values, sized to the counters that compare against them
`define ADCS_RC_TAD_PER     7'h64
`define ADCS_DISCH_LAST     7'h03
`define ADCS_INSTR_LAST     7'h03
`define ADCS_HOLDOFF_LAST   7'h07
`define ADCS_CONV_LAST      5'h0C

`endif

//--- adcs_sequencer.v
// successive-approximation conversion sequencer with apb registers
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`include "adcs_defines.vh"

// Behaviour
// - conversion takes exactly 13 bit periods
// - seven clock sources, 110 is 64, x11 rc
// - codes 000,100,001,101,010 give 2..32 periods
// - rc source gives fixed 2.5 us period
// - acq field bits 5:3, auto sample then convert
// - manual start converts one instruction later
// - acq code 010 gives 4 period acquisition
// - clearing start aborts conversion at once
// - abort leaves result pair untouched
// - completion clears start, sets done flag
// - two instruction hold-off after end or abort
// - then acquisition restarts by itself
// - holding capacitor discharged before every sample
module adcs_sequencer
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	input  wire        cmp_in,
	output wire        sample_en,
	output wire        discharge_en,
	output wire        conv_busy,
	output reg  [11:0] dac_code,
	output reg         irq
);

	localparam [6:0] S_IDLE  = 7'h01;
	localparam [6:0] S_DISCH = 7'h02;
	localparam [6:0] S_SAMP  = 7'h04;
	localparam [6:0] S_ACQ   = 7'h08;
	localparam [6:0] S_DLY   = 7'h10;
	localparam [6:0] S_CONV  = 7'h20;
	localparam [6:0] S_HOLD  = 7'h40;
	reg  [6:0]  state_reg;
	reg  [6:0]  state_next;
	reg  [6:0]  cyc_reg;
	reg  [6:0]  cyc_next;
	reg  [4:0]  tad_reg;
	reg  [4:0]  tad_next;
	reg  [3:0]  bit_reg;
	reg  [3:0]  bit_next;
	reg  [11:0] sar_next;
	reg         enable_reg;
	reg         start_reg;
	reg         start_next;
	reg  [2:0]  clk_sel_reg;
	reg  [2:0]  acq_sel_reg;
	reg  [11:0] result_reg;
	reg  [11:0] result_next;
	reg  [1:0]  status_reg;
	reg  [1:0]  mask_reg;
	reg  [1:0]  rd_status_reg;
	reg  [1:0]  events;
	reg         cmp_meta_reg;
	reg         cmp_sync_reg;
	reg  [4:0]  acq_len;
	reg  [11:0] resolved;
	reg  [31:0] rd_mux;
	reg         rd_hit;
	wire        tad_tick;
	wire        wr_en;
	wire        rd_en;
	// acquisition length table in bit periods, code 000 is manual
	function [4:0] acq_tads;
		input [2:0] code;
		begin
			case (code)
				3'h1:    acq_tads = 5'd2;
				3'h2:    acq_tads = 5'd4;
				3'h3:    acq_tads = 5'd6;
				3'h4:    acq_tads = 5'd8;
				3'h5:    acq_tads = 5'd12;
				3'h6:    acq_tads = 5'd16;
				3'h7:    acq_tads = 5'd20;
				default: acq_tads = 5'd0;
			endcase
		end
	endfunction
	adcs_tad_gen u_tad
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.run      (state_reg == S_ACQ || state_reg == S_CONV),
		.clk_sel  (clk_sel_reg),
		.tad_tick (tad_tick)
	);
	assign pready       = ce;
	assign wr_en        = psel && penable && ce && pwrite;
	assign rd_en        = psel && penable && ce && !pwrite;
	assign sample_en    = state_reg[2] | state_reg[3];
	assign discharge_en = state_reg[1];
	assign conv_busy    = state_reg[5];
	// comparator comes from the analogue side, not from pclk logic
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmp_meta_reg <= 1'b0;
			cmp_sync_reg <= 1'b0;
		end
		else if (ce)
		begin
			cmp_meta_reg <= cmp_in;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end
	always @*
	begin
		acq_len  = acq_tads(acq_sel_reg);
		resolved = dac_code;
		if (!cmp_sync_reg)
			resolved[bit_reg] = 1'b0;
	end
	// sequencing
	always @*
	begin
		state_next  = state_reg;
		cyc_next    = cyc_reg;
		tad_next    = tad_reg;
		bit_next    = bit_reg;
		sar_next    = dac_code;
		result_next = result_reg;
		start_next  = start_reg;
		events      = 2'b00;
		if (wr_en && paddr == `ADCS_OFF_CTRL)
			start_next = pwdata[`ADCS_CTRL_START] & pwdata[`ADCS_CTRL_ENABLE];
		if (wr_en && paddr == `ADCS_OFF_RESULT)
			result_next = pwdata[11:0];
		case (state_reg)
			S_IDLE:
			begin
				if (enable_reg)
				begin
					state_next = S_DISCH;
					cyc_next   = 7'd0;
				end
			end
			S_DISCH:
			begin
				// empty the capacitor array so each sample starts from zero charge
				if (cyc_reg == `ADCS_DISCH_LAST)
					state_next = S_SAMP;
				else
					cyc_next = cyc_reg + 7'd1;
			end
			S_SAMP:
			begin
				if (start_reg)
				begin
					cyc_next = 7'd0;
					tad_next = 5'd0;
					if (acq_len == 5'd0)
						state_next = S_DLY;
					else
						state_next = S_ACQ;
				end
			end
			S_ACQ:
			begin
				if (tad_tick)
				begin
					if (tad_reg == acq_len - 5'd1)
					begin
						state_next = S_CONV;
						tad_next   = 5'd0;
						bit_next   = 4'd11;
						sar_next   = 12'h800;
					end
					else
						tad_next = tad_reg + 5'd1;
				end
			end
			S_DLY:
			begin
				// one instruction of slack lets the core enter sleep first
				if (cyc_reg == `ADCS_INSTR_LAST)
				begin
					state_next = S_CONV;
					tad_next   = 5'd0;
					bit_next   = 4'd11;
					sar_next   = 12'h800;
				end
				else
					cyc_next = cyc_reg + 7'd1;
			end
			S_CONV:
			begin
				// period 0 settles the msb trial, periods 1..12 resolve one bit each
				if (tad_tick)
				begin
					tad_next = tad_reg + 5'd1;
					if (tad_reg != 5'd0)
					begin
						sar_next = resolved;
						if (bit_reg != 4'd0)
						begin
							bit_next           = bit_reg - 4'd1;
							sar_next[bit_next] = 1'b1;
						end
					end
					if (tad_reg == `ADCS_CONV_LAST)
					begin
						state_next  = S_HOLD;
						cyc_next    = 7'd0;
						result_next = resolved;
						events[`ADCS_ST_DONE] = 1'b1;
						// a fresh start written in this very cycle survives
						if (!(wr_en && paddr == `ADCS_OFF_CTRL))
							start_next = 1'b0;
					end
				end
			end
			S_HOLD:
			begin
				if (cyc_reg == `ADCS_HOLDOFF_LAST)
				begin
					state_next = S_DISCH;
					cyc_next   = 7'd0;
				end
				else
					cyc_next = cyc_reg + 7'd1;
			end
			default:
				state_next = S_IDLE;
		endcase
		// start cleared mid-sequence: drop partial bits, result kept
		if ((state_reg == S_ACQ || state_reg == S_DLY || state_reg == S_CONV)
			&& !start_next && state_next != S_HOLD)
		begin
			state_next            = S_HOLD;
			cyc_next              = 7'd0;
			events[`ADCS_ST_ABORT] = 1'b1;
		end
		if (!enable_reg)
		begin
			state_next = S_IDLE;
			start_next = 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg  <= S_IDLE;
			cyc_reg    <= 7'd0;
			tad_reg    <= 5'd0;
			bit_reg    <= 4'd0;
			dac_code   <= 12'h000;
			start_reg  <= 1'b0;
			result_reg <= `ADCS_RESULT_RST;
		end
		else if (ce)
		begin
			state_reg  <= state_next;
			cyc_reg    <= cyc_next;
			tad_reg    <= tad_next;
			bit_reg    <= bit_next;
			dac_code   <= sar_next;
			start_reg  <= start_next;
			result_reg <= result_next;
		end
	end
	// register file
	always @*
	begin
		rd_hit = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			`ADCS_OFF_CTRL:   rd_mux[1:0] = {start_reg, enable_reg};
			`ADCS_OFF_CONFIG: rd_mux[5:0] = {acq_sel_reg, clk_sel_reg};
			`ADCS_OFF_RESULT: rd_mux[11:0] = result_reg;
			`ADCS_OFF_STATUS: rd_mux[1:0] = status_reg;
			`ADCS_OFF_MASK:   rd_mux[1:0] = mask_reg;
			`ADCS_OFF_STATE:  rd_mux[6:0] = state_reg;
			default:          rd_hit = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_reg    <= 1'b0;
			clk_sel_reg   <= `ADCS_CLK_SEL_RST;
			acq_sel_reg   <= `ADCS_ACQ_SEL_RST;
			mask_reg      <= `ADCS_MASK_RST;
			status_reg    <= `ADCS_STATUS_RST;
			rd_status_reg <= 2'b00;
			prdata        <= 32'h00000000;
			pslverr       <= 1'b0;
			irq           <= 1'b0;
		end
		else if (ce)
		begin
			// read data is captured in the setup cycle and held through access
			if (psel && !penable)
			begin
				prdata        <= pwrite ? 32'h00000000 : rd_mux;
				pslverr       <= !rd_hit;
				rd_status_reg <= (!pwrite && paddr == `ADCS_OFF_STATUS) ? status_reg : 2'b00;
			end
			if (wr_en && paddr == `ADCS_OFF_CTRL)
				enable_reg <= pwdata[`ADCS_CTRL_ENABLE];
			if (wr_en && paddr == `ADCS_OFF_CONFIG)
			begin
				clk_sel_reg <= pwdata[`ADCS_CLK_SEL_MSB:`ADCS_CLK_SEL_LSB];
				acq_sel_reg <= pwdata[`ADCS_ACQ_SEL_MSB:`ADCS_ACQ_SEL_LSB];
			end
			if (wr_en && paddr == `ADCS_OFF_MASK)
				mask_reg <= pwdata[1:0];
			// only bits that were actually read are cleared; a new event wins
			if (rd_en && paddr == `ADCS_OFF_STATUS)
				status_reg <= (status_reg & ~rd_status_reg) | events;
			else
				status_reg <= status_reg | events;
			irq <= |((status_reg | events) & mask_reg);
		end
	end

endmodule

//--- adcs_sequencer_assertions.sv
// port checker for the conversion sequencer
`timescale 1ns/1ps
module adcs_seq_checker
(
	input wire		pclk,
	input wire		presetn,
	input wire		ce,
	input wire		psel,
	input wire		penable,
	input wire		pwrite,
	input wire [11:0]	paddr,
	input wire [31:0]	pwdata,
	input wire		pready,
	input wire [31:0]	prdata,
	input wire		pslverr,
	input wire		cmp_in,
	input wire		sample_en,
	input wire		discharge_en,
	input wire		conv_busy,
	input wire [11:0]	dac_code,
	input wire		irq
);
default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);
wire	setup = psel && !penable && ce;
wire	hit = paddr <= 12'h014 && paddr[1:0] == 2'h0;
property p_ready;
	pready == ce;
endproperty
a_ready: assert property (p_ready) else $error("ready differs from enable");
property p_err;
	setup && !hit |=> pslverr;
endproperty
a_err: assert property (p_err) else $error("unmapped access not refused");
property p_ok;
	setup && hit |=> !pslverr;
endproperty
a_ok: assert property (p_ok) else $error("mapped access refused");
property p_phase;
	$onehot0({sample_en, discharge_en, conv_busy});
endproperty
a_phase: assert property (p_phase) else $error("two phases at once");
property p_busy;
	$rose(conv_busy) |-> conv_busy[*8];
endproperty
a_busy: assert property (p_busy) else $error("conversion too short");
property p_dis_first;
	$rose(sample_en) |-> $past(discharge_en);
endproperty
a_dis_first: assert property (p_dis_first) else $error("sample without discharge");
property p_dis_len;
	$rose(discharge_en) |-> discharge_en[*4] ##1 !discharge_en;
endproperty
a_dis_len: assert property (p_dis_len) else $error("discharge length wrong");
property p_hold;
	$fell(conv_busy) |-> (!sample_en && !discharge_en)[*8] ##1 discharge_en;
endproperty
a_hold: assert property (p_hold) else $error("hold-off wrong");
property p_irq;
	$rose(irq) |-> $past(conv_busy, 2);
endproperty
a_irq: assert property (p_irq) else $error("interrupt without event");
endmodule
bind adcs_sequencer adcs_seq_checker u_chk
(
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .cmp_in(cmp_in), .sample_en(sample_en),
	.discharge_en(discharge_en), .conv_busy(conv_busy), .dac_code(dac_code), .irq(irq)
);

//--- adcs_tad_gen.v
// conversion bit period tick generator, divided oscillator or internal rc
`timescale 1ns/1ps
`include "adcs_defines.vh"

module adcs_tad_gen
(
	input  wire       pclk,
	input  wire       presetn,
	input  wire       ce,
	input  wire       run,
	input  wire [2:0] clk_sel,
	output reg        tad_tick
);

	reg  [6:0] cnt_reg;
	reg  [6:0] period;

	always @*
	begin
		case (clk_sel)
			// two clocks outrun the comparator synchroniser, bits need three or more
			`ADCS_CLK_DIV2:  period = 7'd2;
			`ADCS_CLK_DIV4:  period = 7'd4;
			`ADCS_CLK_DIV8:  period = 7'd8;
			`ADCS_CLK_DIV16: period = 7'd16;
			`ADCS_CLK_DIV32: period = 7'd32;
			`ADCS_CLK_DIV64: period = 7'd64;
			// x11: rc source, fixed bit period of 100 core clock cycles
			default:         period = `ADCS_RC_TAD_PER;
		endcase
	end

	// preloaded to one while idle: the registered tick then lands a whole period after run rises
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg  <= 7'h00;
			tad_tick <= 1'b0;
		end
		else if (ce)
		begin
			if (!run)
			begin
				cnt_reg  <= 7'h01;
				tad_tick <= 1'b0;
			end
			else if (cnt_reg >= period - 7'd1)
			begin
				cnt_reg  <= 7'h00;
				tad_tick <= 1'b1;
			end
			else
			begin
				cnt_reg  <= cnt_reg + 7'd1;
				tad_tick <= 1'b0;
			end
		end
	end

endmodule
